// File: core/tcr_pkg.sv
// tcr_pkg: constants, enumerations and carrier types for the timer
// capture/compare register unit.
// assumes a byte-wide register port and a 50 MHz peripheral clock.

package tcr_pkg;

    // register offsets on the byte register port
    localparam logic [3:0] TCR_OFF_IRQ_ENABLE    = 4'h5;
    localparam logic [3:0] TCR_OFF_IRQ_FLAGS     = 4'h6;
    localparam logic [3:0] TCR_OFF_RUN_STATE     = 4'h7;
    localparam logic [3:0] TCR_OFF_DEBUG         = 4'h8;
    localparam logic [3:0] TCR_OFF_STAGING       = 4'h9;
    localparam logic [3:0] TCR_OFF_COUNTER_LO    = 4'hA;
    localparam logic [3:0] TCR_OFF_COUNTER_HI    = 4'hB;
    localparam logic [3:0] TCR_OFF_COMPARE_LO    = 4'hC;
    localparam logic [3:0] TCR_OFF_COMPARE_HI    = 4'hD;

    // field positions (all single-bit fields sit in bit 0)
    localparam int         TCR_BIT_SNAPSHOT_IRQ  = 0;
    localparam int         TCR_BIT_RUN           = 0;
    localparam int         TCR_BIT_KEEP_GOING    = 0;

    // reset values and the counter increment
    localparam logic [7:0]  TCR_RST_BYTE         = 8'h00;
    localparam logic [15:0] TCR_RST_WORD         = 16'h0000;
    localparam logic [15:0] TCR_ONE_WORD         = 16'h0001;

    // counting modes, encoded as the mode field
    typedef enum logic [2:0] {
        TCR_MODE_INT     = 3'b000,
        TCR_MODE_TIMEOUT = 3'b001,
        TCR_MODE_SNAPSHOT_IRQ    = 3'b010,
        TCR_MODE_FRQ     = 3'b011,
        TCR_MODE_PW      = 3'b100,
        TCR_MODE_FRQPW   = 3'b101,
        TCR_MODE_SINGLE  = 3'b110,
        TCR_MODE_PWM8    = 3'b111
    } tcr_mode_t;

    // phases of combined frequency and pulse-width measurement
    typedef enum logic [1:0] {
        TCR_PH_IDLE = 2'b00,
        TCR_PH_SNAPSHOT_IRQ = 2'b01,
        TCR_PH_STOP = 2'b10
    } tcr_phase_t;

    // one register port request, valid for one mclk cycle
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } tcr_bus_req_t;

endpackage : tcr_pkg

// File: core/tcr_timer_capture.sv
// tcr_timer_capture: interrupt, status, debug, staging, counter and
// capture/compare registers of a 16-bit timer/counter with capture.
// assumes mode, edge select, event enable, timer enable and the count tick
// come from the neighbouring control logic, all synchronous to mclk.

`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - irq_enable bit 0 enables snapshot interrupt
// - irq_flags bit 0 set on mode condition
// - flag cleared by write-one or capture read
// - timer modes flag when counter equals TOP
// - frequency mode: capture, restart, flag per edge
// - capture-on-event: capture and flag on event
// - pulse-width: edge restarts, next edge captures
// - freq+pw: flag and stop on third edge
// - pwm8 flags when counter hits period byte
// - run_state bit 0 shows counter running
// - debug bit 0 keeps timer running in break
// - shared byte staging register, software accessible
// - counter readable/writable, low byte at 0x0A
// - bus write beats internal counter update
// - capture register holds counter at capture
// - compare register is TOP in timer modes
// - pwm8 low byte period, high byte duty
// - three-bit mode field selects eight modes
// - edge select inverts edge roles; in single mode it lets either edge start
module tcr_timer_capture (
    input  wire logic               mclk,
    input  wire logic               rst,
    input  wire tcr_pkg::tcr_bus_req_t bus,
    output var  logic [7:0]         reg_rdata,
    input  wire tcr_pkg::tcr_mode_t timer_operating_mode,
    input  wire logic               timer_enable,
    input  wire logic               count_tick,
    input  wire logic               edge_invert,
    input  wire logic               capture_event_enable,
    input  wire logic               event_in,
    input  wire logic               debug_break,
    output logic                    snapshot_irq,
    output logic                    counter_running,
    output logic [7:0]              duty_high_byte
);
    import tcr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // counter plus one, wrapping at the word width
    function automatic logic [15:0] tcr_bump(input logic [15:0] v);
        tcr_bump = v + TCR_ONE_WORD;
    endfunction : tcr_bump

    // modes in which a read of the capture register clears the flag
    function automatic logic tcr_is_capture(input tcr_mode_t m);
        tcr_is_capture = (m == TCR_MODE_SNAPSHOT_IRQ) || (m == TCR_MODE_FRQ) ||
                         (m == TCR_MODE_PW)   || (m == TCR_MODE_FRQPW);
    endfunction : tcr_is_capture

    ////////////////////////////////////////////////////////////////////////
    // state

    logic        irq_enable_reg;        // snapshot interrupt enable
    logic        flag_reg;              // snapshot interrupt flag
    logic        keep_going_reg;        // keep counting in debug break
    logic [7:0]  staging_reg;           // shared high-byte staging
    logic [15:0] counter_reg;           // counter value
    logic [15:0] compare_reg;           // capture/compare value
    logic        run_reg;               // counter running
    logic        event_prev_reg;        // event level one cycle ago
    tcr_phase_t  phase_reg;             // freq+pw measurement phase

    ////////////////////////////////////////////////////////////////////////
    // combinational decode

    logic        halted;                // debug break stops the timer
    logic        pos_edge;              // accepted rising event edge
    logic        neg_edge;              // accepted falling event edge
    logic        act_edge;              // edge that captures / starts
    logic        oth_edge;              // opposite edge
    logic        tick;                  // counting step this cycle
    logic        at_top;                // counter equals TOP
    logic        at_period;             // counter low byte equals period
    logic [15:0] counter_next;          // internal counter update
    logic        capture_now;           // copy counter to compare reg
    logic        flag_set;              // flag condition this cycle
    logic        run_next;              // running state next
    tcr_phase_t  phase_next;            // measurement phase next

    // bus strobes, one per register concern
    logic wr_irq_en, wr_flags, wr_debug, wr_staging;
    logic wr_cnt_lo, wr_cnt_hi, wr_cmp_lo, wr_cmp_hi;
    logic rd_cnt_lo, rd_cmp_lo;

    always_comb begin
        wr_irq_en  = bus.wr && (bus.addr == TCR_OFF_IRQ_ENABLE);
        wr_flags   = bus.wr && (bus.addr == TCR_OFF_IRQ_FLAGS);
        wr_debug   = bus.wr && (bus.addr == TCR_OFF_DEBUG);
        wr_staging = bus.wr && (bus.addr == TCR_OFF_STAGING);
        wr_cnt_lo  = bus.wr && (bus.addr == TCR_OFF_COUNTER_LO);
        wr_cnt_hi  = bus.wr && (bus.addr == TCR_OFF_COUNTER_HI);
        wr_cmp_lo  = bus.wr && (bus.addr == TCR_OFF_COMPARE_LO);
        wr_cmp_hi  = bus.wr && (bus.addr == TCR_OFF_COMPARE_HI);
        rd_cnt_lo  = bus.rd && (bus.addr == TCR_OFF_COUNTER_LO);
        rd_cmp_lo  = bus.rd && (bus.addr == TCR_OFF_COMPARE_LO);
    end

    // edge detection and qualification of the count tick
    always_comb begin
        halted    = debug_break && !keep_going_reg;
        pos_edge  = capture_event_enable && !halted &&
                    event_in && !event_prev_reg;
        neg_edge  = capture_event_enable && !halted &&
                    !event_in && event_prev_reg;
        act_edge  = edge_invert ? neg_edge : pos_edge;
        oth_edge  = edge_invert ? pos_edge : neg_edge;
        tick      = count_tick && timer_enable && !halted;
        at_top    = (counter_reg == compare_reg);
        at_period = (counter_reg[7:0] == compare_reg[7:0]);
    end

    ////////////////////////////////////////////////////////////////////////
    // per-mode sequencing: counter step, capture, flag, run, phase

    always_comb begin
        counter_next = counter_reg;
        capture_now  = 1'b0;
        flag_set     = 1'b0;
        run_next     = run_reg;
        phase_next   = phase_reg;
        if (!timer_enable) begin
            // disabled timer holds its count and forgets measurements
            run_next   = 1'b0;
            phase_next = TCR_PH_IDLE;
        end else begin
            case (timer_operating_mode)
                TCR_MODE_INT: begin
                    run_next = 1'b1;
                    if (tick) begin
                        if (at_top) begin
                            counter_next = TCR_RST_WORD;
                            flag_set     = 1'b1;
                        end else begin
                            counter_next = tcr_bump(counter_reg);
                        end
                    end
                end
                TCR_MODE_TIMEOUT: begin
                    // start and stop edges swap with edge select
                    if (act_edge) begin
                        run_next = 1'b1;
                    end else if (oth_edge) begin
                        run_next = 1'b0;
                    end
                    if (run_reg && tick) begin
                        if (at_top) begin
                            counter_next = TCR_RST_WORD;
                            flag_set     = 1'b1;
                        end else begin
                            counter_next = tcr_bump(counter_reg);
                        end
                    end
                end
                TCR_MODE_SNAPSHOT_IRQ: begin
                    run_next = 1'b1;
                    if (tick) begin
                        counter_next = tcr_bump(counter_reg);
                    end
                    if (act_edge) begin
                        capture_now = 1'b1;
                        flag_set    = 1'b1;
                    end
                end
                TCR_MODE_FRQ: begin
                    run_next = 1'b1;
                    if (act_edge) begin
                        capture_now  = 1'b1;
                        flag_set     = 1'b1;
                        counter_next = TCR_RST_WORD;
                    end else if (tick) begin
                        counter_next = tcr_bump(counter_reg);
                    end
                end
                TCR_MODE_PW: begin
                    run_next = 1'b1;
                    if (act_edge) begin
                        counter_next = TCR_RST_WORD;
                    end else begin
                        if (tick) begin
                            counter_next = tcr_bump(counter_reg);
                        end
                        if (oth_edge) begin
                            capture_now = 1'b1;
                            flag_set    = 1'b1;
                        end
                    end
                end
                TCR_MODE_FRQPW: begin
                    case (phase_reg)
                        TCR_PH_IDLE: begin
                            run_next = 1'b0;
                            if (act_edge) begin
                                counter_next = TCR_RST_WORD;
                                run_next     = 1'b1;
                                phase_next   = TCR_PH_SNAPSHOT_IRQ;
                            end
                        end
                        TCR_PH_SNAPSHOT_IRQ: begin
                            if (tick) begin
                                counter_next = tcr_bump(counter_reg);
                            end
                            if (oth_edge) begin
                                capture_now = 1'b1;
                                phase_next  = TCR_PH_STOP;
                            end
                        end
                        TCR_PH_STOP: begin
                            if (act_edge) begin
                                // count frozen so software sees period
                                run_next   = 1'b0;
                                flag_set   = 1'b1;
                                phase_next = TCR_PH_IDLE;
                            end else if (tick) begin
                                counter_next = tcr_bump(counter_reg);
                            end
                        end
                        default: begin
                            phase_next = TCR_PH_IDLE;
                        end
                    endcase
                end
                TCR_MODE_SINGLE: begin
                    // with edge select set, either edge starts the shot
                    if (!run_reg && (edge_invert ? (pos_edge || neg_edge)
                                                 : pos_edge)) begin
                        run_next     = 1'b1;
                        counter_next = TCR_RST_WORD;
                    end else if (run_reg && tick) begin
                        if (at_top) begin
                            run_next     = 1'b0;
                            counter_next = TCR_RST_WORD;
                            flag_set     = 1'b1;
                        end else begin
                            counter_next = tcr_bump(counter_reg);
                        end
                    end
                end
                TCR_MODE_PWM8: begin
                    run_next = 1'b1;
                    if (tick) begin
                        if (at_period) begin
                            counter_next = TCR_RST_WORD;
                            flag_set     = 1'b1;
                        end else begin
                            counter_next = tcr_bump(counter_reg);
                        end
                    end
                end
                default: begin
                    run_next = 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // counter register: bus writes are applied last so they win

    always_ff @(posedge mclk) begin
        if (rst) begin
            counter_reg <= TCR_RST_WORD;
        end else begin
            counter_reg <= counter_next;
            if (wr_cnt_hi) begin
                counter_reg <= {bus.wdata, staging_reg};
            end
        end
    end

    // capture/compare register: whole-word bus commit, else capture
    always_ff @(posedge mclk) begin
        if (rst) begin
            compare_reg <= TCR_RST_WORD;
        end else if (wr_cmp_hi) begin
            compare_reg <= {bus.wdata, staging_reg};
        end else if (capture_now) begin
            compare_reg <= counter_reg;
        end
    end

    // staging byte: low writes stage, low reads latch the high byte
    always_ff @(posedge mclk) begin
        if (rst) begin
            staging_reg <= TCR_RST_BYTE;
        end else if (wr_staging || wr_cnt_lo || wr_cmp_lo) begin
            staging_reg <= bus.wdata;
        end else if (rd_cnt_lo) begin
            staging_reg <= counter_reg[15:8];
        end else if (rd_cmp_lo) begin
            staging_reg <= compare_reg[15:8];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control bits

    always_ff @(posedge mclk) begin
        if (rst) begin
            irq_enable_reg <= 1'b0;
            keep_going_reg <= 1'b0;
        end else begin
            if (wr_irq_en) begin
                irq_enable_reg <= bus.wdata[TCR_BIT_SNAPSHOT_IRQ];
            end
            if (wr_debug) begin
                keep_going_reg <= bus.wdata[TCR_BIT_KEEP_GOING];
            end
        end
    end

    // interrupt flag: a set in the same cycle as a clear is kept
    always_ff @(posedge mclk) begin
        if (rst) begin
            flag_reg <= 1'b0;
        end else if (flag_set) begin
            flag_reg <= 1'b1;
        end else if ((wr_flags && bus.wdata[TCR_BIT_SNAPSHOT_IRQ]) ||
                     (rd_cmp_lo &&
                      tcr_is_capture(timer_operating_mode))) begin
            flag_reg <= 1'b0;
        end
    end

    // running state, edge history and measurement phase
    always_ff @(posedge mclk) begin
        if (rst) begin
            run_reg        <= 1'b0;
            event_prev_reg <= 1'b0;
            phase_reg      <= TCR_PH_IDLE;
        end else begin
            run_reg        <= run_next;
            event_prev_reg <= event_in;
            phase_reg      <= phase_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data, registered: valid the cycle after the read strobe

    always_ff @(posedge mclk) begin
        if (rst) begin
            reg_rdata <= TCR_RST_BYTE;
        end else if (bus.rd) begin
            case (bus.addr)
                TCR_OFF_IRQ_ENABLE: reg_rdata <= {7'h00, irq_enable_reg};
                TCR_OFF_IRQ_FLAGS:  reg_rdata <= {7'h00, flag_reg};
                // read-only; no port can write it
                TCR_OFF_RUN_STATE:  reg_rdata <= {7'h00, run_reg};
                TCR_OFF_DEBUG:      reg_rdata <= {7'h00, keep_going_reg};
                TCR_OFF_STAGING:    reg_rdata <= staging_reg;
                TCR_OFF_COUNTER_LO: reg_rdata <= counter_reg[7:0];
                TCR_OFF_COUNTER_HI: reg_rdata <= staging_reg;
                TCR_OFF_COMPARE_LO: reg_rdata <= compare_reg[7:0];
                TCR_OFF_COMPARE_HI: reg_rdata <= staging_reg;
                default:            reg_rdata <= TCR_RST_BYTE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign snapshot_irq    = flag_reg && irq_enable_reg;
    assign counter_running = run_reg;
    // duty byte handed to the waveform logic in pwm8 mode
    assign duty_high_byte  = compare_reg[15:8];

endmodule : tcr_timer_capture

`default_nettype wire

// File: dv/tcr_event_source.sv
// tcr_event_source: far-side model of the event routing feeding event_in.
// assumes the bench pulses fire_pulse for one mclk to request one edge.
`timescale 1ns/1ns
`default_nettype none
module tcr_event_source (
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic fire_pulse,
    output var  logic event_line
);
    ////////////////////////////////////////////////////////////////////////
    // each request flips the level once; the line is then held, so the
    // unit sees exactly one edge and no glitch between requests
    always_ff @(posedge mclk) begin
        if (rst) begin
            event_line <= 1'b0;
        end else if (fire_pulse) begin
            event_line <= ~event_line;
        end
    end
endmodule : tcr_event_source
`default_nettype wire

// File: dv/tcr_timer_capture_monitor.sv
// tcr_timer_capture_monitor: port-level assertions for the timer unit.
// assumes one mclk domain and a synchronous active-high rst.
`timescale 1ns/1ns
`default_nettype none
module tcr_timer_capture_monitor
    import tcr_pkg::*;
(
    input wire logic                   mclk,
    input wire logic                   rst,
    input wire tcr_pkg::tcr_bus_req_t  bus,
    input wire logic [7:0]             reg_rdata,
    input wire tcr_pkg::tcr_mode_t     timer_operating_mode,
    input wire logic                   timer_enable,
    input wire logic                   count_tick,
    input wire logic                   edge_invert,
    input wire logic                   capture_event_enable,
    input wire logic                   event_in,
    input wire logic                   debug_break,
    input wire logic                   snapshot_irq,
    input wire logic                   counter_running,
    input wire logic [7:0]             duty_high_byte
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////
    // single-cycle register port strobes at one offset
    sequence wr_at(logic [3:0] a);
        bus.wr && bus.addr == a;
    endsequence
    sequence rd_at(logic [3:0] a);
        bus.rd && bus.addr == a;
    endsequence
    ////////////////////////////////////////////////////////////////////////
    // reset must be checked while reset is high, so no disable here
    reset_zero_a: assert property (disable iff (1'b0)
        rst |=> !snapshot_irq && !counter_running && reg_rdata == 8'h00)
        else $error("outputs not cleared by reset");
    irq_mask_a: assert property (
        wr_at(TCR_OFF_IRQ_ENABLE) ##0 !bus.wdata[0] |=> !snapshot_irq)
        else $error("irq still high after enable cleared");
    // with counting and events off nothing can set the flag again
    irq_clear_a: assert property (wr_at(TCR_OFF_IRQ_FLAGS) ##0
        (bus.wdata[0] && !timer_enable && !capture_event_enable)
        |=> !snapshot_irq) else $error("flag not cleared by write one");
    duty_follow_a: assert property (
        wr_at(TCR_OFF_COMPARE_HI) |=> duty_high_byte == $past(bus.wdata))
        else $error("duty byte not taken from high compare write");
    run_stop_a: assert property (
        !timer_enable [*2] |-> !counter_running)
        else $error("run bit high while timer disabled");
    staging_rw_a: assert property (wr_at(TCR_OFF_STAGING) ##1
        (!bus.wr && !bus.rd) ##1 rd_at(TCR_OFF_STAGING)
        |=> reg_rdata == $past(bus.wdata, 3))
        else $error("staging read differs from written byte");
    read_hold_a: assert property (!bus.rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");
    unmapped_zero_a: assert property (
        bus.rd && (bus.addr < TCR_OFF_IRQ_ENABLE || bus.addr > 4'hD)
        |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
endmodule : tcr_timer_capture_monitor

bind tcr_timer_capture tcr_timer_capture_monitor u_mon (.mclk(mclk),
    .rst(rst), .bus(bus), .reg_rdata(reg_rdata),
    .timer_operating_mode(timer_operating_mode),
    .timer_enable(timer_enable), .count_tick(count_tick),
    .edge_invert(edge_invert), .capture_event_enable(capture_event_enable),
    .event_in(event_in), .debug_break(debug_break),
    .snapshot_irq(snapshot_irq), .counter_running(counter_running),
    .duty_high_byte(duty_high_byte));
`default_nettype wire

// File: dv/tcr_timer_capture_tb_top.sv
// tcr_timer_capture_tb_top: register-level bench for the timer unit.
// assumes the event model on event_in; inputs change 2 ns after mclk rises.
`timescale 1ns/1ns
`default_nettype none
module tcr_timer_capture_tb_top;
    import tcr_pkg::*;
    logic         mclk = 1'b0;
    logic         rst, ten, tick, einv, ceen, dbrk, fire, ev, irq, run;
    tcr_bus_req_t bus_q;            // register port request
    tcr_mode_t    mode_q;           // counting mode level
    logic [7:0]   rdata, duty, v8;
    logic [15:0]  v16;
    int           num_errors = 0;
    int           compares = 0;
    always #10 mclk = ~mclk;        // 50 MHz
    tcr_timer_capture uut (.mclk(mclk), .rst(rst), .bus(bus_q),
        .reg_rdata(rdata), .timer_operating_mode(mode_q),
        .timer_enable(ten), .count_tick(tick), .edge_invert(einv),
        .capture_event_enable(ceen), .event_in(ev), .debug_break(dbrk),
        .snapshot_irq(irq), .counter_running(run), .duty_high_byte(duty));
    tcr_event_source u_ev (.mclk(mclk), .rst(rst), .fire_pulse(fire),
        .event_line(ev));
    ////////////////////////////////////////////////////////////////////////
    task automatic print_verdict;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : print_verdict
    task automatic check(input string nm, input logic [15:0] seen,
                         input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    // one strobe cycle then one idle cycle, so strobes never merge
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus_q = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge mclk); #2;
        bus_q = '0;
        @(posedge mclk); #2;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        bus_q = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge mclk); #2;
        bus_q = '0;
        d = rdata;                  // registered answer of the read edge
        @(posedge mclk); #2;
    endtask : rd
    task automatic wr16(input logic [3:0] a, input logic [15:0] d);
        wr(a, d[7:0]);              // low byte goes to staging first
        wr(a + 4'h1, d[15:8]);
    endtask : wr16
    task automatic rd16(input logic [3:0] a, output logic [15:0] d);
        rd(a, d[7:0]);
        rd(a + 4'h1, d[15:8]);
    endtask : rd16
    task automatic wait_irq;
        for (int i = 0; i < 64; i++) begin
            if (irq === 1'b1) return;
            @(posedge mclk); #2;
        end
        num_errors++;
        print_verdict();
    endtask : wait_irq
    task automatic kick;            // one event edge, then let it land
        fire = 1'b1;
        @(posedge mclk); #2;
        fire = 1'b0;
        repeat (3) @(posedge mclk);
        #2;
    endtask : kick
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {rst, ten, tick, einv, ceen, dbrk, fire} = 7'b100_0000;
        bus_q = '0;
        mode_q = TCR_MODE_INT;
        repeat (12) @(posedge mclk);
        #2;
        rst = 1'b0;
        for (int a = 0; a < 16; a++) begin
            rd(4'(a), v8);
            check("reset read", 16'(v8), 16'h0000);
        end
        wr(TCR_OFF_IRQ_ENABLE, 8'h01);
        rd(TCR_OFF_IRQ_ENABLE, v8);
        check("irq enable", 16'(v8), 16'h0001);
        wr(TCR_OFF_STAGING, 8'h5A);
        rd(TCR_OFF_STAGING, v8);
        check("staging", 16'(v8), 16'h005A);
        wr(TCR_OFF_RUN_STATE, 8'hFF);
        rd(TCR_OFF_RUN_STATE, v8);
        check("run state", 16'(v8), 16'h0000);
        wr16(TCR_OFF_COMPARE_LO, 16'h0003);
        {tick, ten} = 2'b11;
        wait_irq();
        check("top irq", 16'(irq), 16'h0001);
        ten = 1'b0;
        wr(TCR_OFF_IRQ_FLAGS, 8'h01);
        check("write one", 16'(irq), 16'h0000);
        ten = 1'b1;                 // tick lands on the edge after the high-byte write
        wr16(TCR_OFF_COUNTER_LO, 16'h1234);
        ten = 1'b0;
        wr(TCR_OFF_IRQ_FLAGS, 8'h01);
        rd16(TCR_OFF_COUNTER_LO, v16);
        check("count write", v16, 16'h1235);
        mode_q = TCR_MODE_SNAPSHOT_IRQ;     // counter frozen: tick low
        {ten, tick, ceen} = 3'b101;
        kick();
        wait_irq();
        rd16(TCR_OFF_COMPARE_LO, v16);
        check("capture", v16, 16'h1235);
        check("read clear", 16'(irq), 16'h0000);
        rd(TCR_OFF_RUN_STATE, v8);
        check("run bit", 16'(v8), 16'h0001);
        dbrk = 1'b1;                // halted: both edges ignored
        kick();
        kick();
        check("halted", 16'(irq), 16'h0000);
        wr(TCR_OFF_DEBUG, 8'h01);
        kick();
        kick();
        wait_irq();
        rd16(TCR_OFF_COMPARE_LO, v16);
        check("dbg run", v16, 16'h1235);
        dbrk = 1'b0;
        mode_q = TCR_MODE_FRQ;
        wr16(TCR_OFF_COUNTER_LO, 16'h0042);
        kick();
        kick();
        wait_irq();
        rd16(TCR_OFF_COUNTER_LO, v16);
        check("restart", v16, 16'h0000);
        rd16(TCR_OFF_COMPARE_LO, v16);
        check("frq capture", v16, 16'h0042);
        mode_q = TCR_MODE_PW;       // inverted: falling clears
        einv = 1'b1;
        wr16(TCR_OFF_COUNTER_LO, 16'h0099);
        kick();
        rd16(TCR_OFF_COUNTER_LO, v16);
        check("pw clear", v16, 16'h0000);
        wr16(TCR_OFF_COUNTER_LO, 16'h0077);
        kick();
        wait_irq();
        rd16(TCR_OFF_COMPARE_LO, v16);
        check("pw capture", v16, 16'h0077);
        mode_q = TCR_MODE_PWM8;
        wr16(TCR_OFF_COMPARE_LO, 16'h8002);
        check("duty", 16'(duty), 16'h0080);
        wr16(TCR_OFF_COUNTER_LO, 16'h0000);
        tick = 1'b1;
        wait_irq();
        check("period irq", 16'(irq), 16'h0001);
        ten = 1'b0;
        wr(TCR_OFF_IRQ_ENABLE, 8'h00);
        check("masked", 16'(irq), 16'h0000);
        wr(TCR_OFF_IRQ_FLAGS, 8'h01);
        mode_q = TCR_MODE_FRQPW;
        ten = 1'b1;
        repeat (3) kick();
        rd(TCR_OFF_IRQ_FLAGS, v8);
        check("frqpw flag", 16'(v8), 16'h0001);
        check("stopped", 16'(run), 16'h0000);
        rd16(TCR_OFF_COMPARE_LO, v16);
        check("frqpw width", v16, 16'h0003);
        rd16(TCR_OFF_COUNTER_LO, v16);
        check("frqpw stop", v16, 16'h0007);
        print_verdict();
    end
endmodule : tcr_timer_capture_tb_top
`default_nettype wire
